/* ssc_map.svh */
// register offsets, command codes, window bounds and bit counts for the spi command decoder
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH

`define SSC_REG_LOG_ADDR 15'h0009
`define SSC_REG_CCW_ADDR 15'h000D
`define SSC_REG_PTR 15'h000F
`define SSC_PTR_RESET 15'h0000
`define SSC_LOG_FIRST 15'h0040
`define SSC_LOG_LAST 15'h005F
`define SSC_CMD_LAST_BIT 4'h7
`define SSC_WORD_LAST_BIT 4'hF

`define SSC_CMD_ADD1 8'hD0
`define SSC_CMD_ADD2 8'hD8
`define SSC_CMD_ADD4 8'hE0
`define SSC_CMD_RD_PTR 8'h40
`define SSC_CMD_WR_PTR 8'hC0
`define SSC_CMD_RD_INC 8'h48
`define SSC_CMD_WR_INC 8'hC8
`define SSC_CMD_RD_CW 8'h50
`define SSC_CMD_RD_IND0 8'h68
`define SSC_CMD_RD_IND1 8'h70
`define SSC_CMD_RD_IND2 8'h78
`define SSC_CMD_WR_IND0 8'hE8
`define SSC_CMD_WR_IND1 8'hF0
`define SSC_CMD_WR_IND2 8'hF8
`define SSC_CMD_POLL 8'h60
`define SSC_CMD_RD_LOG 8'h58

`endif

/* ssc_pkg.sv */
// types shared by the spi command decoder modules
package ssc_pkg;

  typedef enum logic [4:0] {
    S_CMD = 5'b00001,
    S_FETCH = 5'b00010,
    S_READ = 5'b00100,
    S_WRITE = 5'b01000,
    S_DONE = 5'b10000
  } ssc_state_type;

  typedef enum logic [2:0] {
    STEP_INC = 3'b001,
    STEP_ADD4 = 3'b010,
    STEP_DEC = 3'b100
  } ssc_step_type;

endpackage

/* ssc_pin_sync.sv */
// two-flop synchronisers with edge pulses for the serial pins
`timescale 1ns/100ps
`default_nettype none

module ssc_pin_sync #(
  parameter int WIDTH = 3
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stable;
  logic [WIDTH-1:0] prev;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      meta <= '0;
      stable <= '0;
      prev <= '0;
    end
    else
    begin
      meta <= pinIn;
      stable <= meta;
      prev <= stable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // edges seen only past the second flop
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_edge
      assign level[i] = stable[i];
      assign rise[i] = stable[i] & ~prev[i];
      assign fall[i] = ~stable[i] & prev[i];
    end
  endgenerate

endmodule

`default_nettype wire

/* ssc_word_buffer.sv */
// small valid/ready buffer holding outgoing write words
`timescale 1ns/100ps
`default_nettype none

module ssc_word_buffer #(
  parameter int WIDTH = 31,
  parameter int DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic [AW-1:0] next_wrPtr;
  logic [AW-1:0] next_rdPtr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign inReady = (count != FULL);
  assign outValid = (count != '0);
  assign outData = store[rdPtr];

  always_comb
  begin
    push = inValid && inReady;
    pop = outValid && outReady;
    next_wrPtr = push ? ((wrPtr == LAST) ? '0 : wrPtr + AW'(1)) : wrPtr;
    next_rdPtr = pop ? ((rdPtr == LAST) ? '0 : rdPtr + AW'(1)) : rdPtr;
    next_count = count;
    if (push && !pop)
    begin
      next_count = count + (AW + 1)'(1);
    end
    else if (pop && !push)
    begin
      next_count = count - (AW + 1)'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      store[wrPtr] <= inData;
    end
  end

endmodule

`default_nettype wire

/* ssc_command_decoder.sv */
// spi slave host port: command decode, address pointer and word transfer
//
// Behaviour
// [RL1] command byte opens every transaction
// [RL2] host discards byte read during command
// [RL3] command bit 7 selects read or write
// [RL4] fast access: bits 5:2 pick register
// [RL5] fast access moves one word after command; code goes on to the next register while clocks continue
// [RL6] other commands use pointer in register 15
// [RL7] pointer loaded via 0xBC, 15 bits wide
// [RL8] each finished word advances the address
// [RL9] pointer wraps from 0x7FFF to zero
// [RL10] 0xD0/D8/E0 add 1/2/4, no data
// [RL11] host never chains two command bytes
// [RL12] fast access leaves primary pointer untouched
// [RL13] 0x40/0xC0 use pointer as is
// [RL14] 0x48/0xC8 increment pointer, then transfer
// [RL15] 0x50 loads control word address, reads
// [RL16] 0x68/70/78 add, load pointer indirect, read
// [RL17] 0xE8/F0/F8 add, load pointer indirect, write
// [RL18] reading control word clears block accessed flag
// [RL19] 0x60 reads then adds four per word
// [RL20] log address is even within log window
// [RL21] 0x58 starts at log address minus one
// [RL22] log reads decrement, wrapping inside window
// [RL23] bytes msb first, high byte first
// [RL24] chip enable negation resets serial logic
// [RL25] output driven only while sending read data
// [RL26] sample on rising, change on falling
// [RL27] unknown commands ignored until chip enable negates
`timescale 1ns/100ps
`default_nettype none
`include "ssc_map.svh"

module ssc_command_decoder
  import ssc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic chipEnableN,
  input wire logic sck,
  input wire logic si,
  output logic soOut,
  output logic soOe,
  output logic memRdReq,
  output logic [14:0] memRdAddr,
  input wire logic [15:0] memRdData,
  input wire logic memRdValid,
  output logic memWrValid,
  input wire logic memWrReady,
  output logic [14:0] memWrAddr,
  output logic [15:0] memWrData,
  input wire logic [15:0] currentControlWordAddress,
  input wire logic [15:0] interruptLogNextAddress,
  output logic blockAccessedClear,
  output logic [14:0] blockAccessedAddr,
  output logic [14:0] primaryAddressPointer
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] pinLevel;
  logic [2:0] pinRise;
  logic [2:0] pinFall;
  logic ceOff;
  logic siLvl;
  logic sckRise;
  logic sckFall;

  ssc_pin_sync #(
    .WIDTH(3)
  ) u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .pinIn({chipEnableN, sck, si}),
    .level(pinLevel),
    .rise(pinRise),
    .fall(pinFall)
  );

  assign ceOff = pinLevel[2];
  assign siLvl = pinLevel[0];
  assign sckRise = pinRise[1];
  assign sckFall = pinFall[1];

  ////////////////////////////////////////////////////////////////////////////////
  // state
  ssc_state_type state, next_state;
  ssc_step_type step, next_step;
  logic [3:0] bitCnt, next_bitCnt;
  logic [3:0] txIdx, next_txIdx;
  logic [15:0] rxShift, next_rxShift;
  logic [15:0] txWord, next_txWord;
  logic [14:0] ptr, next_ptr;
  logic [14:0] fastPtr, next_fastPtr;
  logic usePrimary, next_usePrimary;
  logic indirect, next_indirect;
  logic wrAfter, next_wrAfter;
  logic cwOnce, next_cwOnce;
  logic pollAll, next_pollAll;
  logic reqIssued, next_reqIssued;
  logic wrPend, next_wrPend;
  logic [14:0] wrPendAddr, next_wrPendAddr;
  logic [15:0] wrPendData, next_wrPendData;
  logic next_soOut;
  logic next_soOe;
  logic next_memRdReq;
  logic [14:0] next_memRdAddr;
  logic next_blockAccessedClear;
  logic [14:0] next_blockAccessedAddr;
  logic bufInReady;
  logic [14:0] curAddr;
  logic [7:0] cmdByte;
  logic [15:0] word;
  logic [15:0] fetched;
  logic gotData;

  assign curAddr = usePrimary ? ptr : fastPtr;
  assign primaryAddressPointer = ptr;

  function automatic logic isLocal(input logic [14:0] a);
    isLocal = (a == `SSC_REG_PTR) || (a == `SSC_REG_CCW_ADDR) || (a == `SSC_REG_LOG_ADDR);
  endfunction

  // next address after a finished word
  function automatic logic [14:0] stepAddr(input logic [14:0] a, input ssc_step_type s);
    unique case (s)
      STEP_ADD4: stepAddr = a + 15'h0004; // RL19
      STEP_DEC: stepAddr = (a == `SSC_LOG_FIRST) ? `SSC_LOG_LAST : a - 15'h0001; // RL22
      default: stepAddr = a + 15'h0001; // RL9
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    next_state = state;
    next_step = step;
    next_bitCnt = bitCnt;
    next_txIdx = txIdx;
    next_rxShift = rxShift;
    next_txWord = txWord;
    next_ptr = ptr;
    next_fastPtr = fastPtr;
    next_usePrimary = usePrimary;
    next_indirect = indirect;
    next_wrAfter = wrAfter;
    next_cwOnce = cwOnce;
    next_pollAll = pollAll;
    next_reqIssued = reqIssued;
    next_soOut = soOut;
    next_soOe = soOe;
    next_memRdReq = 1'b0;
    next_memRdAddr = memRdAddr;
    next_blockAccessedClear = 1'b0;
    next_blockAccessedAddr = blockAccessedAddr;
    cmdByte = {rxShift[6:0], siLvl};
    word = {rxShift[14:0], siLvl};
    fetched = memRdData;
    gotData = 1'b0;
    // write word leaves once the buffer takes it
    next_wrPend = wrPend && !bufInReady;
    next_wrPendAddr = wrPendAddr;
    next_wrPendData = wrPendData;
    if (ceOff)
    begin
      // partial byte dropped, output released
      next_state = S_CMD; // RL24
      next_bitCnt = 4'h0;
      next_soOe = 1'b0;
      next_soOut = 1'b0;
      next_reqIssued = 1'b0;
      next_indirect = 1'b0;
      next_wrAfter = 1'b0;
    end
    else
    begin
      unique case (state)
        S_CMD:
        begin
          if (sckRise)
          begin
            next_rxShift = {rxShift[14:0], siLvl}; // RL26
            next_bitCnt = bitCnt + 4'h1;
            if (bitCnt == `SSC_CMD_LAST_BIT) // RL1
            begin
              next_bitCnt = 4'h0;
              next_reqIssued = 1'b0;
              next_usePrimary = 1'b1;
              next_step = STEP_INC;
              next_indirect = 1'b0;
              next_wrAfter = 1'b0;
              next_cwOnce = 1'b0;
              next_pollAll = 1'b0;
              next_state = S_FETCH;
              if (!cmdByte[6] && cmdByte[1:0] == 2'b00)
              begin
                next_usePrimary = 1'b0; // RL12
                next_fastPtr = {11'h000, cmdByte[5:2]}; // RL4
                if (cmdByte[7]) // RL3
                begin
                  next_state = S_WRITE; // RL5
                end
              end
              else
              begin
                unique case (cmdByte) // RL6
                  `SSC_CMD_ADD1: begin next_ptr = ptr + 15'h0001; next_state = S_DONE; end // RL10
                  `SSC_CMD_ADD2: begin next_ptr = ptr + 15'h0002; next_state = S_DONE; end // RL10
                  `SSC_CMD_ADD4: begin next_ptr = ptr + 15'h0004; next_state = S_DONE; end // RL10
                  `SSC_CMD_RD_PTR: next_state = S_FETCH; // RL13
                  `SSC_CMD_WR_PTR: next_state = S_WRITE; // RL13
                  `SSC_CMD_RD_INC: next_ptr = ptr + 15'h0001; // RL14
                  `SSC_CMD_WR_INC:
                  begin
                    next_ptr = ptr + 15'h0001; // RL14
                    next_state = S_WRITE;
                  end
                  `SSC_CMD_RD_CW:
                  begin
                    next_ptr = currentControlWordAddress[14:0]; // RL15
                    next_cwOnce = 1'b1;
                  end
                  `SSC_CMD_RD_IND0: next_indirect = 1'b1; // RL16
                  `SSC_CMD_RD_IND1: begin next_ptr = ptr + 15'h0001; next_indirect = 1'b1; end // RL16
                  `SSC_CMD_RD_IND2: begin next_ptr = ptr + 15'h0002; next_indirect = 1'b1; end // RL16
                  `SSC_CMD_WR_IND0: begin next_indirect = 1'b1; next_wrAfter = 1'b1; end // RL17
                  `SSC_CMD_WR_IND1:
                  begin
                    next_ptr = ptr + 15'h0001; // RL17
                    next_indirect = 1'b1;
                    next_wrAfter = 1'b1;
                  end
                  `SSC_CMD_WR_IND2:
                  begin
                    next_ptr = ptr + 15'h0002; // RL17
                    next_indirect = 1'b1;
                    next_wrAfter = 1'b1;
                  end
                  `SSC_CMD_POLL:
                  begin
                    next_step = STEP_ADD4; // RL19
                    next_pollAll = 1'b1;
                  end
                  `SSC_CMD_RD_LOG:
                  begin
                    next_step = STEP_DEC; // RL22
                    // log address is even, so minus one is the last written word
                    next_ptr = (interruptLogNextAddress[14:0] == `SSC_LOG_FIRST) ?
                      `SSC_LOG_LAST : interruptLogNextAddress[14:0] - 15'h0001; // RL21 RL20
                  end
                  default: next_state = S_DONE; // RL27
                endcase
              end
            end
          end
        end
        S_FETCH:
        begin
          if (!reqIssued)
          begin
            if (isLocal(curAddr))
            begin
              gotData = 1'b1;
              fetched = (curAddr == `SSC_REG_PTR) ? {1'b0, ptr} :
                (curAddr == `SSC_REG_CCW_ADDR) ? currentControlWordAddress : interruptLogNextAddress;
            end
            else
            begin
              next_memRdReq = 1'b1;
              next_memRdAddr = curAddr;
              next_reqIssued = 1'b1;
            end
          end
          else if (memRdValid)
          begin
            gotData = 1'b1;
          end
          if (gotData)
          begin
            next_reqIssued = 1'b0;
            next_bitCnt = 4'h0;
            if (indirect)
            begin
              next_ptr = fetched[14:0]; // RL16 RL17
              next_indirect = 1'b0;
              if (wrAfter)
              begin
                next_state = S_WRITE;
              end
            end
            else
            begin
              next_txWord = fetched;
              next_txIdx = 4'h0;
              next_state = S_READ;
            end
          end
        end
        S_READ:
        begin
          // input ignored while sending
          if (sckFall)
          begin
            next_soOut = txWord[~txIdx]; // RL23 RL26
            next_soOe = 1'b1; // RL25
            next_txIdx = txIdx + 4'h1;
          end
          if (sckRise)
          begin
            next_bitCnt = bitCnt + 4'h1;
            if (bitCnt == 4'h0 && (cwOnce || pollAll))
            begin
              next_blockAccessedClear = 1'b1; // RL18
              next_blockAccessedAddr = curAddr;
              next_cwOnce = 1'b0;
            end
            if (bitCnt == `SSC_WORD_LAST_BIT)
            begin
              next_state = S_FETCH; // RL8
              if (usePrimary)
              begin
                next_ptr = stepAddr(ptr, step);
              end
              else
              begin
                next_fastPtr = fastPtr + 15'h0001;
              end
            end
          end
        end
        S_WRITE:
        begin
          if (sckRise)
          begin
            next_rxShift = {rxShift[14:0], siLvl}; // RL23
            next_bitCnt = bitCnt + 4'h1;
            if (bitCnt == `SSC_WORD_LAST_BIT)
            begin
              if (!usePrimary)
              begin
                next_fastPtr = fastPtr + 15'h0001; // RL8
              end
              if (curAddr == `SSC_REG_PTR)
              begin
                next_ptr = word[14:0]; // RL7
              end
              else
              begin
                if (curAddr != `SSC_REG_CCW_ADDR && curAddr != `SSC_REG_LOG_ADDR)
                begin
                  next_wrPend = 1'b1;
                  next_wrPendAddr = curAddr;
                  next_wrPendData = word;
                end
                if (usePrimary)
                begin
                  next_ptr = stepAddr(ptr, STEP_INC); // RL8 RL9
                end
              end
            end
          end
        end
        S_DONE:
        begin
          next_bitCnt = 4'h0; // RL11 RL27
        end
        default:
        begin
          next_state = S_CMD;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state <= S_CMD;
      step <= STEP_INC;
      bitCnt <= 4'h0;
      txIdx <= 4'h0;
      rxShift <= 16'h0000;
      txWord <= 16'h0000;
      ptr <= `SSC_PTR_RESET;
      fastPtr <= 15'h0000;
      usePrimary <= 1'b1;
      indirect <= 1'b0;
      wrAfter <= 1'b0;
      cwOnce <= 1'b0;
      pollAll <= 1'b0;
      reqIssued <= 1'b0;
      wrPend <= 1'b0;
      wrPendAddr <= 15'h0000;
      wrPendData <= 16'h0000;
      soOut <= 1'b0;
      soOe <= 1'b0;
      memRdReq <= 1'b0;
      memRdAddr <= 15'h0000;
      blockAccessedClear <= 1'b0;
      blockAccessedAddr <= 15'h0000;
    end
    else
    begin
      state <= next_state;
      step <= next_step;
      bitCnt <= next_bitCnt;
      txIdx <= next_txIdx;
      rxShift <= next_rxShift;
      txWord <= next_txWord;
      ptr <= next_ptr;
      fastPtr <= next_fastPtr;
      usePrimary <= next_usePrimary;
      indirect <= next_indirect;
      wrAfter <= next_wrAfter;
      cwOnce <= next_cwOnce;
      pollAll <= next_pollAll;
      reqIssued <= next_reqIssued;
      wrPend <= next_wrPend;
      wrPendAddr <= next_wrPendAddr;
      wrPendData <= next_wrPendData;
      soOut <= next_soOut;
      soOe <= next_soOe;
      memRdReq <= next_memRdReq;
      memRdAddr <= next_memRdAddr;
      blockAccessedClear <= next_blockAccessedClear;
      blockAccessedAddr <= next_blockAccessedAddr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write words queue toward the memory port
  ssc_word_buffer #(
    .WIDTH(31),
    .DEPTH(2)
  ) u_wrbuf (
    .core_clk(core_clk),
    .rstn(rstn),
    .inValid(wrPend),
    .inReady(bufInReady),
    .inData({wrPendAddr, wrPendData}),
    .outValid(memWrValid),
    .outReady(memWrReady),
    .outData({memWrAddr, memWrData})
  );

endmodule

`default_nettype wire

/* ssc_command_decoder_properties.sv */
// concurrent checks on the spi command decoder ports
`timescale 1ns/100ps
`default_nettype none

module ssc_command_decoder_properties (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic chipEnableN,
  input wire logic sck,
  input wire logic si,
  input wire logic soOut,
  input wire logic soOe,
  input wire logic memRdReq,
  input wire logic [14:0] memRdAddr,
  input wire logic [15:0] memRdData,
  input wire logic memRdValid,
  input wire logic memWrValid,
  input wire logic memWrReady,
  input wire logic [14:0] memWrAddr,
  input wire logic [15:0] memWrData,
  input wire logic [15:0] currentControlWordAddress,
  input wire logic [15:0] interruptLogNextAddress,
  input wire logic blockAccessedClear,
  input wire logic [14:0] blockAccessedAddr,
  input wire logic [14:0] primaryAddressPointer
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  a_oe_needs_ce: assert property (chipEnableN [*6] |-> !soOe)
    else $error("serial output driven with chip enable high");
  a_so_after_fall: assert property (soOe && $changed(soOut) |-> !$past(sck, 2))
    else $error("serial output changed outside the low clock phase");
  a_clear_with_read: assert property (blockAccessedClear |-> soOe && blockAccessedAddr == primaryAddressPointer)
    else $error("flag clear not tied to the control word read");
  a_clear_single: assert property (blockAccessedClear |=> !blockAccessedClear)
    else $error("flag clear longer than one cycle");
  a_read_spacing: assert property (memRdReq |=> !memRdReq)
    else $error("second read request while one is outstanding");
  a_read_local_regs: assert property (memRdReq |-> !(memRdAddr inside {15'h0009, 15'h000D, 15'h000F}))
    else $error("register served locally was requested from memory");
  a_write_hold: assert property (memWrValid && !memWrReady |=> memWrValid && $stable(memWrAddr) && $stable(memWrData))
    else $error("write word changed or lost while stalled");
  a_write_local_regs: assert property (memWrValid |-> !(memWrAddr inside {15'h0009, 15'h000D, 15'h000F}))
    else $error("write to a local register reached memory");
  a_ptr_idle_still: assert property (chipEnableN [*8] |=> $stable(primaryAddressPointer))
    else $error("pointer moved with no transaction");
endmodule

`default_nettype wire

/* ssc_spi_host.sv */
// host spi master model driving the serial pins in mode 0
`timescale 1ns/100ps
`default_nettype none

module ssc_spi_host (
  input wire logic core_clk,
  input wire logic soOut,
  input wire logic soOe,
  output logic chipEnableN,
  output logic sck,
  output logic si
);
  logic junk = 1'b0;
  logic soLine;

  // released line shows a toggling pattern
  always @(posedge core_clk) junk <= ~junk;
  assign soLine = soOe ? soOut : junk;

  initial
  begin
    chipEnableN = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic shift(input logic [15:0] tx, input int nBits, output logic [15:0] rx);
    rx = '0;
    for (int i = 15; i > 15 - nBits; i--)
    begin
      si = tx[i];
      #400 sck = 1'b1;
      #(i > 16 - nBits ? 300 : 700) rx[i] = soLine;
      #100 sck = 1'b0;
    end
  endtask

  task automatic xfer(input logic [7:0] cmd, input int nWords, input logic [15:0] w0, input logic [15:0] w1,
                      output logic [15:0] r0, output logic [15:0] r1);
    logic [15:0] dummy;
    @(posedge core_clk);
    #13 chipEnableN = 1'b0;
    #400 shift({cmd, 8'h00}, 8, dummy);
    #1600;
    if (nWords > 0) shift(w0, 16, r0);
    if (nWords > 1) shift(w1, 16, r1);
    #400 chipEnableN = 1'b1;
    si = ~si;
    #1000;
  endtask

  task automatic abort(input logic [3:0] bits);
    logic [15:0] dummy;
    @(posedge core_clk);
    #13 chipEnableN = 1'b0;
    #400 shift({bits, 12'h000}, 4, dummy);
    #400 chipEnableN = 1'b1;
    #1000;
  endtask
endmodule

`default_nettype wire

/* ssc_command_decoder_test.sv */
// testbench for the spi command decoder
`timescale 1ns/100ps
`default_nettype none
`include "ssc_map.svh"

module ssc_command_decoder_test;
  logic core_clk, rstn, chipEnableN, sck, si, soOut, soOe;
  logic memRdReq, memRdValid, memWrValid, memWrReady, blockAccessedClear, stall;
  logic [14:0] memRdAddr, memWrAddr, blockAccessedAddr, primaryAddressPointer, lastClr;
  logic [15:0] memRdData, memWrData, ccwAddr, logAddr, r0, r1;
  logic [15:0] mem [0:32767];
  int n_errors, compares, cycles, nClr, c0;

  ssc_command_decoder dut_u (.core_clk, .rstn, .chipEnableN, .sck, .si, .soOut, .soOe, .memRdReq, .memRdAddr,
    .memRdData, .memRdValid, .memWrValid, .memWrReady, .memWrAddr, .memWrData,
    .currentControlWordAddress(ccwAddr), .interruptLogNextAddress(logAddr), .blockAccessedClear,
    .blockAccessedAddr, .primaryAddressPointer);
  ssc_spi_host hostU (.core_clk, .soOut, .soOe, .chipEnableN, .sck, .si);

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // memory partner, stalled writes, flag clear monitor and timeout
  always @(posedge core_clk)
  begin
    memRdValid <= memRdReq;
    memRdData <= memRdReq ? mem[memRdAddr] : ~memRdData;
    if (memWrValid && memWrReady) mem[memWrAddr] <= memWrData;
    memWrReady <= stall ? 1'b0 : cycles[1];
    if (blockAccessedClear) lastClr <= blockAccessedAddr;
    nClr <= nClr + (blockAccessedClear ? 1 : 0);
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      n_errors++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] pat(input logic [15:0] a);
    return a ^ 16'h5A5A;
  endfunction

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic run(input logic [7:0] cmd, input int n, input logic [15:0] w0 = 16'h0000,
                     input logic [15:0] w1 = 16'h0000);
    hostU.xfer(cmd, n, w0, w1, r0, r1);
  endtask

  task automatic setPtr(input logic [15:0] a);
    run(8'hBC, 1, a);
  endtask

  task automatic ptrIs(input logic [15:0] a);
    check("pointer", a, {1'b0, primaryAddressPointer});
  endtask

  task automatic results;
    if (n_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_fast;
    setPtr(16'h0100);
    ptrIs(16'h0100);
    run(8'h3C, 1);
    check("pointer read", 16'h0100, r0);
    run(8'h14, 1);
    check("reg5", pat(16'h0005), r0);
    ptrIs(16'h0100);
  endtask

  task automatic t_write;
    setPtr(16'h0120);
    stall = 1'b1;
    run(`SSC_CMD_WR_PTR, 2, 16'h1234, 16'hBEEF);
    check("held valid", 16'h0001, {15'h0000, memWrValid});
    check("held mem", pat(16'h0120), mem[15'h0120]);
    stall = 1'b0;
    repeat (20) @(posedge core_clk);
    check("mem0", 16'h1234, mem[15'h0120]);
    check("mem1", 16'hBEEF, mem[15'h0121]);
    ptrIs(16'h0122);
    setPtr(16'h0120);
    run(`SSC_CMD_RD_PTR, 2);
    check("rd0", 16'h1234, r0);
    check("rd1", 16'hBEEF, r1);
    run(`SSC_CMD_WR_INC, 1, 16'h4321);
    check("mem2", 16'h4321, mem[15'h0123]);
  endtask

  task automatic t_add;
    logic [7:0] cmds [3] = '{`SSC_CMD_ADD1, `SSC_CMD_ADD2, `SSC_CMD_ADD4};
    logic [15:0] adds [3] = '{16'h0001, 16'h0002, 16'h0004};
    for (int k = 0; k < 3; k++)
    begin
      setPtr(16'h0300);
      run(cmds[k], 0);
      ptrIs(16'h0300 + adds[k]);
    end
  endtask

  task automatic t_wrap;
    setPtr(16'h7FFE);
    run(`SSC_CMD_RD_INC, 2);
    check("top", pat(16'h7FFF), r0);
    check("wrapped", pat(16'h0000), r1);
  endtask

  task automatic t_control;
    c0 = nClr;
    run(`SSC_CMD_RD_CW, 2);
    check("cw", pat(16'h0200), r0);
    check("cw next", pat(16'h0201), r1);
    check("clears", 16'h0001, 16'(nClr - c0));
    check("clear addr", 16'h0200, {1'b0, lastClr});
    setPtr(16'h0200);
    c0 = nClr;
    run(`SSC_CMD_POLL, 2);
    check("poll0", pat(16'h0200), r0);
    check("poll1", pat(16'h0204), r1);
    check("poll clears", 16'h0002, 16'(nClr - c0));
    ptrIs(16'h0208);
  endtask

  task automatic t_log;
    run(`SSC_CMD_RD_LOG, 2);
    check("log0", pat(16'h005F), r0);
    check("log1", pat(16'h005E), r1);
    @(posedge core_clk) logAddr <= 16'h0042;
    run(`SSC_CMD_RD_LOG, 2);
    check("log2", pat(16'h0041), r0);
    check("log3", pat(16'h0040), r1);
    ptrIs(16'h005F);
  endtask

  task automatic t_indirect;
    for (int k = 0; k < 3; k++)
    begin
      mem[16'h0300 + k] = 16'(16'h0400 + 16'h0010 * k);
      setPtr(16'h0300);
      run(`SSC_CMD_RD_IND0 + 8'(8 * k), 2);
      check("ind rd0", pat(16'(16'h0400 + 16'h0010 * k)), r0);
      check("ind rd1", pat(16'(16'h0401 + 16'h0010 * k)), r1);
      mem[16'h0310 + k] = 16'(16'h0500 + 16'h0010 * k);
      setPtr(16'h0310);
      run(`SSC_CMD_WR_IND0 + 8'(8 * k), 1, 16'(16'h7700 + k));
      repeat (10) @(posedge core_clk);
      check("ind wr", 16'(16'h7700 + k), mem[16'h0500 + 16 * k]);
    end
  endtask

  task automatic t_abort;
    setPtr(16'h0123);
    hostU.abort(4'hB);
    run(8'h3C, 1);
    check("after abort", 16'h0123, r0);
    run(8'h01, 1, 16'hFFFF);
    ptrIs(16'h0123);
  endtask

  initial
  begin
    rstn = 1'b0;
    stall = 1'b0;
    memWrReady = 1'b0;
    memRdValid = 1'b0;
    memRdData = 16'h0000;
    ccwAddr = 16'h0200;
    logAddr = 16'h0040;
    for (int i = 0; i < 32768; i++) mem[i] = pat(16'(i));
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_fast();
    t_write();
    t_add();
    t_wrap();
    t_control();
    t_log();
    t_indirect();
    t_abort();
    results();
  end
endmodule

bind ssc_command_decoder ssc_command_decoder_properties chk_u (.core_clk, .rstn, .chipEnableN, .sck, .si, .soOut,
  .soOe, .memRdReq, .memRdAddr, .memRdData, .memRdValid, .memWrValid, .memWrReady, .memWrAddr, .memWrData,
  .currentControlWordAddress, .interruptLogNextAddress, .blockAccessedClear, .blockAccessedAddr,
  .primaryAddressPointer);

`default_nettype wire
